// ---- nv_shadow_host_regs.vh ----
/*
 * constants for the host-side controller of the shadowed static memory:
 * sequence addresses, bus timing counts and nonvolatile wait counts.
 * assumes the includer runs at the 40 MHz system clock (25 ns period).
 */
`ifndef NV_SHADOW_HOST_REGS_VH
`define NV_SHADOW_HOST_REGS_VH

// ==========================================================================
// clock
// ==========================================================================
`define CLK_PERIOD_NS        25

// ==========================================================================
// memory geometry
// ==========================================================================
`define ADDR_W               13
`define DATA_W               8
`define MEM_BYTES            8192

// ==========================================================================
// unlock sequence addresses
// ==========================================================================
`define SEQ_ADDR_0           13'h0000
`define SEQ_ADDR_1           13'h1555
`define SEQ_ADDR_2           13'h0aaa
`define SEQ_ADDR_3           13'h1fff
`define SEQ_ADDR_4           13'h10f0
`define SEQ_ADDR_SAVE        13'h0f0f
`define SEQ_ADDR_RESTORE     13'h0f0e
`define SEQ_STEPS            3'h6

// ==========================================================================
// bus timing, ns and derived cycles (least times round up)
// ==========================================================================
`define ACCESS_TIME_NS       45
`define ACCESS_CYC           ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_TIME_NS        30
`define SETUP_CYC            ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_TIME_NS      25
`define RECOVER_CYC          ((`RECOVER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// nonvolatile operation waits, default figures in us
// ==========================================================================
`define SAVE_TIME_US         10000
`define RESTORE_TIME_US      20
`define POWERUP_TIME_US      550
`define US_TO_CYC(us)        (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- nv_wait_timer.v ----
/*
 * down-counting wait timer: loads a cycle count on a start pulse and
 * raises done for one cycle when it expires.
 * assumes the count fits in 24 bits and start is not reissued while busy.
 */
`timescale 1ns/1ps
`default_nettype none

module nv_wait_timer (
  input  wire        i_clk_sys,   // system clock
  input  wire        i_rst,       // async reset, active high
  input  wire        i_start,     // load pulse
  input  wire [23:0] i_count,     // cycles to wait, at least one
  output reg         o_busy,      // counting
  output reg         o_done       // one-cycle expiry pulse
);

  reg [23:0] cnt_q;  // remaining cycles

  // ========================================================================
  // counter
  // ========================================================================
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 24'h000000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        // a zero count would wrap through the whole 24-bit range before expiring, so force one cycle
        cnt_q  <= (i_count == 24'h000000) ? 24'h000001 : i_count;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (cnt_q == 24'h000001) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_q <= cnt_q - 24'h000001;
      end
    end
  end

endmodule // nv_wait_timer

`default_nettype wire

// ---- nv_shadow_host.v ----
/*
 * host-side controller for an 8K x 8 static memory with a nonvolatile
 * shadow. it runs single reads and writes over the parallel pins and
 * issues the six-read unlock sequence for save and restore, then waits
 * out the nonvolatile cycle time before allowing further accesses.
 * assumes the memory sits on the pins with no other master, and that
 * pin inputs are synchronous to i_clk_sys.
 */
// Notes on behaviour
// - host holds address through write
// - host keeps gate high when writing
// - save unlock starts 0000 1555 0aaa
// - then 1fff 10f0 0f0f starts save
// - sequence steps are select-controlled reads
// - 0f0e as sixth read restores
// - strobe high through all six steps
`timescale 1ns/1ps
`default_nettype none
`include "nv_shadow_host_regs.vh"

module nv_shadow_host #(
  parameter [23:0] SAVE_CYC    = `US_TO_CYC(`SAVE_TIME_US),    // save wait
  parameter [23:0] RESTORE_CYC = `US_TO_CYC(`RESTORE_TIME_US), // restore wait
  parameter [23:0] POWERUP_CYC = `US_TO_CYC(`POWERUP_TIME_US)  // power-up wait
) (
  input  wire        i_clk_sys,     // system clock, 40 MHz
  input  wire        i_rst,         // async reset, active high
  input  wire        i_req,         // command request, level
  input  wire [1:0]  i_cmd,         // 0 read, 1 write, 2 save, 3 restore
  input  wire [12:0] i_addr,        // byte address
  input  wire [7:0]  i_wdata,       // write byte
  output reg         o_ready,       // idle, command can be taken
  output reg         o_rvalid,      // read byte valid, one cycle
  output reg  [7:0]  o_rdata,       // read byte
  output reg         o_nv_done,     // save or restore finished, one cycle
  output reg  [12:0] o_addr_bus,    // memory address pins
  output reg  [7:0]  o_data_bus,    // data pins, host drive value
  output reg         o_data_bus_oe, // high while host drives data pins
  input  wire [7:0]  i_data_bus,    // data pins as seen
  output reg         o_ce_n,        // chip select, active low
  output reg         o_we_n,        // write strobe, active low
  output reg         o_oe_n         // output gate, active low
);

  // one-hot states
  localparam [6:0] ST_POWER = 7'h01;  // waiting out power-up restore
  localparam [6:0] ST_IDLE  = 7'h02;  // bus quiet
  localparam [6:0] ST_RD    = 7'h04;  // read strobe held
  localparam [6:0] ST_WR    = 7'h08;  // write strobe held
  localparam [6:0] ST_SEQ   = 7'h10;  // unlock read held
  localparam [6:0] ST_GAP   = 7'h20;  // select high between accesses
  localparam [6:0] ST_NV    = 7'h40;  // nonvolatile cycle in progress

  localparam [1:0] CMD_RD = 2'h0;
  localparam [1:0] CMD_WR = 2'h1;
  localparam [1:0] CMD_SV = 2'h2;

  reg  [6:0]  state_q;    // current state
  reg  [3:0]  cnt_q;      // strobe and gap cycle counter
  reg  [2:0]  step_q;     // unlock step index
  reg         restore_q;  // sequence ends in restore
  reg         after_q;    // gap leads into a nonvolatile wait
  reg         tmr_start;  // timer load pulse
  reg  [23:0] tmr_count;  // timer load value
  wire        tmr_done;   // timer expiry
  wire        tmr_busy;   // timer running

  // unlock address for a step; the last step picks save or restore
  function [12:0] seq_addr;
    input [2:0] step;
    input       rst_sel;
    begin
      case (step)
        3'h0:    seq_addr = `SEQ_ADDR_0;
        3'h1:    seq_addr = `SEQ_ADDR_1;
        3'h2:    seq_addr = `SEQ_ADDR_2;
        3'h3:    seq_addr = `SEQ_ADDR_3;
        3'h4:    seq_addr = `SEQ_ADDR_4;
        // restore ends on its own address
        default: seq_addr = rst_sel ? `SEQ_ADDR_RESTORE : `SEQ_ADDR_SAVE;
      endcase
    end
  endfunction

  // ========================================================================
  // nonvolatile wait timer
  // ========================================================================
  nv_wait_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (tmr_start),
    .i_count   (tmr_count),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // ========================================================================
  // timer load: power-up right after reset, save or restore after step six
  // ========================================================================
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tmr_start <= 1'b0;
      tmr_count <= 24'h000000;
    end else begin
      tmr_start <= 1'b0;
      if (state_q == ST_POWER && !tmr_busy && !tmr_start && !tmr_done) begin
        tmr_start <= 1'b1;
        tmr_count <= POWERUP_CYC;
      end else if (state_q == ST_GAP && after_q && cnt_q == 4'h0) begin
        tmr_start <= 1'b1;
        tmr_count <= restore_q ? RESTORE_CYC : SAVE_CYC;
      end
    end
  end

  // ========================================================================
  // main bus sequencer
  // ========================================================================
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q       <= ST_POWER;
      cnt_q         <= 4'h0;
      step_q        <= 3'h0;
      restore_q     <= 1'b0;
      after_q       <= 1'b0;
      o_ready       <= 1'b0;
      o_rvalid      <= 1'b0;
      o_rdata       <= 8'h00;
      o_nv_done     <= 1'b0;
      o_addr_bus    <= 13'h0000;
      o_data_bus    <= 8'h00;
      o_data_bus_oe <= 1'b0;
      o_ce_n        <= 1'b1;
      o_we_n        <= 1'b1;
      o_oe_n        <= 1'b1;
    end else begin
      o_rvalid  <= 1'b0;
      o_nv_done <= 1'b0;
      case (state_q)
        ST_POWER: begin
          // the memory recalls by itself; keep it deselected till done
          if (tmr_done) begin
            state_q <= ST_IDLE;
            o_ready <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (i_req) begin
            o_ready <= 1'b0;
            cnt_q   <= 4'h0;
            o_addr_bus <= i_addr;
            if (i_cmd == CMD_RD) begin
              state_q <= ST_RD;
              o_ce_n  <= 1'b0;
              o_oe_n  <= 1'b0;
            end else if (i_cmd == CMD_WR) begin
              // gate stays high
              // select stays high here so the address settles first
              state_q       <= ST_WR;
              o_data_bus    <= i_wdata;
              o_data_bus_oe <= 1'b1;
              o_we_n        <= 1'b0;
            end else begin
              state_q    <= ST_SEQ;
              step_q     <= 3'h0;
              restore_q  <= (i_cmd != CMD_SV);
              o_addr_bus <= seq_addr(3'h0, 1'b0);
              o_ce_n     <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (cnt_q == `ACCESS_CYC - 1) begin
            o_rdata  <= i_data_bus;
            o_rvalid <= 1'b1;
            o_ce_n   <= 1'b1;
            o_oe_n   <= 1'b1;
            state_q  <= ST_GAP;
            cnt_q    <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_WR: begin
          // address and data held to the select edge
          if (cnt_q == 4'h0) begin
            // address stable a cycle before select falls
            o_ce_n <= 1'b0;
            cnt_q  <= 4'h1;
          end else if (cnt_q == `SETUP_CYC) begin
            o_ce_n  <= 1'b1;
            o_we_n  <= 1'b1;
            state_q <= ST_GAP;
            cnt_q   <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_SEQ: begin
          if (cnt_q == `ACCESS_CYC - 1) begin
            o_ce_n  <= 1'b1;
            state_q <= ST_GAP;
            cnt_q   <= 4'h0;
            after_q <= (step_q == `SEQ_STEPS - 3'h1);
            step_q  <= step_q + 3'h1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_GAP: begin
          // select high for a recovery time between accesses
          if (after_q) begin
            if (cnt_q == 4'h0) begin
              cnt_q   <= 4'h1;
            end else begin
              state_q <= ST_NV;
              after_q <= 1'b0;
            end
          end else if (cnt_q == `RECOVER_CYC - 1) begin
            cnt_q <= 4'h0;
            // steps back to back, no stray access
            if (step_q != 3'h0 && step_q != `SEQ_STEPS) begin
              state_q    <= ST_SEQ;
              o_addr_bus <= seq_addr(step_q, restore_q);
              o_ce_n     <= 1'b0;
            end else begin
              state_q       <= ST_IDLE;
              step_q        <= 3'h0;
              o_data_bus_oe <= 1'b0;
              o_ready       <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_NV: begin
          if (tmr_done) begin
            state_q   <= ST_IDLE;
            step_q    <= 3'h0;
            o_nv_done <= 1'b1;
            o_ready   <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          o_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // nv_shadow_host

`default_nettype wire

// ---- nv_shadow_host_assertions.sv ----
/* pin and handshake checker for the host controller of the shadowed memory.
   assumes it is bound to every controller instance and shares its clock. */
`timescale 1ns/1ps
`default_nettype none
module nv_shadow_host_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_req,
  input wire logic [1:0]  i_cmd,
  input wire logic [12:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        o_ready,
  input wire logic        o_rvalid,
  input wire logic [12:0] o_addr_bus,
  input wire logic [7:0]  o_data_bus,
  input wire logic        o_data_bus_oe,
  input wire logic        o_ce_n,
  input wire logic        o_we_n,
  input wire logic        o_oe_n
);
  // ==========================================================
  // one clock domain, reset quiets everything
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire take = i_req && o_ready; // command accepted this edge
  // ==========================================================
  // pin discipline
  a_gate_off_write: assert property (!o_we_n |-> o_oe_n)
    else $error("gate low in write");
  a_no_contention: assert property (o_data_bus_oe |-> o_oe_n)
    else $error("host drives while gate low");
  a_addr_hold_write: assert property ((!o_ce_n && !o_we_n) ##1 (!o_ce_n && !o_we_n)
    |-> $stable(o_addr_bus)) else $error("address moved in write");
  a_write_pins: assert property (take && i_cmd == 2'h1 |=> o_ce_n && !o_we_n
    && o_data_bus_oe && o_addr_bus == $past(i_addr) && o_data_bus == $past(i_wdata)
    ##1 (!o_ce_n && !o_we_n)) else $error("write pins wrong");
  a_addr_setup_write: assert property ($fell(o_ce_n) && !o_we_n |-> $stable(o_addr_bus))
    else $error("address not settled before write");
  a_data_to_end: assert property ($rose(o_we_n) |-> o_data_bus_oe)
    else $error("data dropped before strobe end");
  a_read_walk: assert property (take && i_cmd == 2'h0 |=> (!o_ce_n && !o_oe_n && o_we_n)
    ##2 (o_rvalid && o_ce_n)) else $error("read walk wrong");
  // ==========================================================
  // unlock sequence
  a_seq_start: assert property (take && i_cmd[1] |=> (!o_ce_n && o_addr_bus == 13'h0000)
    ##3 (!o_ce_n && o_addr_bus == 13'h1555)) else $error("sequence start wrong");
  a_save_tail: assert property (take && i_cmd == 2'h2 |-> ##13 o_addr_bus == 13'h10f0
    ##3 (!o_ce_n && o_addr_bus == 13'h0f0f)) else $error("save tail wrong");
  a_restore_tail: assert property (take && i_cmd == 2'h3 |-> ##13 o_addr_bus == 13'h10f0
    ##3 (!o_ce_n && o_addr_bus == 13'h0f0e)) else $error("restore tail wrong");
  a_seq_strobe_high: assert property (take && i_cmd[1] |=> (o_we_n && o_oe_n)[*8])
    else $error("strobe low in sequence");
endmodule // nv_shadow_host_checker
bind nv_shadow_host nv_shadow_host_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_addr_bus(o_addr_bus),
  .o_data_bus(o_data_bus), .o_data_bus_oe(o_data_bus_oe), .o_ce_n(o_ce_n),
  .o_we_n(o_we_n), .o_oe_n(o_oe_n));
`default_nettype wire

// ---- nv_mem_model.sv ----
/* behavioural shadowed memory sampled on the system clock.
   assumes reset stands in for power-up and pins change only after edges. */
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model #(
  // nonvolatile busy spans as cycle counts
  parameter int SAVE_T    = 30, // save busy cycles
  parameter int RESTORE_T = 20  // restore busy cycles
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [12:0] i_addr_bus,
  input  wire logic [7:0]  i_data_bus,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic      [7:0]  o_data_bus,
  output logic      [7:0]  o_saves,
  output logic      [7:0]  o_restores,
  output logic      [7:0]  o_deaf_hits
);
  // unlock address expected at a step below the last
  function automatic logic [12:0] seq_at(input logic [2:0] s);
    case (s)
      3'h0:    return 13'h0000;
      3'h1:    return 13'h1555;
      3'h2:    return 13'h0aaa;
      3'h3:    return 13'h1fff;
      default: return 13'h10f0;
    endcase
  endfunction
  logic [7:0] ram [0:8191];  // volatile cells
  logic [7:0] nv  [0:8191];  // shadow cells
  logic [2:0] step_q;        // unlock progress
  int         busy_q;        // nonvolatile cycles left
  logic       ce_q, we_q;    // pins one edge ago
  logic [7:0] last_q;        // released bus shows its inverse, never a stale copy
  logic       drive;
  initial for (int i = 0; i < 8192; i++) nv[i] = i[7:0] ^ 8'h5a;
  // drive only in a plain read
  // data settles within a clock, inside the host's access wait
  assign drive      = !i_ce_n && !i_oe_n && i_we_n && busy_q == 0;
  assign o_data_bus = drive ? ram[i_addr_bus] : ~last_q;
  // ==========================================================
  // access and unlock detection
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8192; i++) ram[i] <= nv[i];
      {step_q, busy_q, ce_q, we_q, last_q} <= {3'h0, 32'h0, 2'b11, 8'h00};
      {o_saves, o_restores, o_deaf_hits} <= 24'h0;
    end else begin
      if (drive) last_q <= o_data_bus;
      if (busy_q > 0) begin
        // deaf until the wait ends; the tail of the sixth
        // read is no new access, so only a fresh select counts as a hit
        busy_q <= busy_q - 1;
        if (ce_q && !i_ce_n) o_deaf_hits <= o_deaf_hits + 8'h01;
      // nothing below reacts while select stays high
      end else if (!ce_q && !we_q && (i_ce_n || i_we_n)) begin
        ram[i_addr_bus] <= i_data_bus;
        step_q <= 3'h0;
      end else if (ce_q && !i_ce_n && i_we_n) begin
        if (step_q == 3'h5 && i_addr_bus == 13'h0f0f) begin
          for (int i = 0; i < 8192; i++) begin
            nv[i] <= 8'hff;
            nv[i] <= ram[i];
          end
          {busy_q, step_q} <= {SAVE_T, 3'h0};
          o_saves <= o_saves + 8'h01;
        end else if (step_q == 3'h5 && i_addr_bus == 13'h0f0e) begin
          for (int i = 0; i < 8192; i++) begin
            ram[i] <= 8'h00;
            ram[i] <= nv[i];
          end
          {busy_q, step_q} <= {RESTORE_T, 3'h0};
          o_restores <= o_restores + 8'h01;
        end else if (step_q < 3'h5 && i_addr_bus == seq_at(step_q)) step_q <= step_q + 3'h1;
        else step_q <= (i_addr_bus == 13'h0000) ? 3'h1 : 3'h0;
      end
      {ce_q, we_q} <= {i_ce_n, i_we_n};
    end
  end
endmodule // nv_mem_model
`default_nettype wire

// ---- nv_shadow_host_tb.sv ----
/* self-checking bench: host controller against the memory model.
   assumes the checker is bound in and waits are shortened by parameters. */
`timescale 1ns/1ps
`default_nettype none
module nv_shadow_host_tb;
  logic        i_clk_sys = 0, i_rst = 1, i_req = 0;
  logic [1:0]  i_cmd     = 0;
  logic [12:0] i_addr    = 0;
  logic [7:0]  i_wdata   = 0, rd_v;
  wire         ready, rvalid, nv_done, host_oe, ce_n, we_n, oe_n;
  wire  [7:0]  rdata, host_d, mem_d, data_w, saves, restores, deaf;
  wire  [12:0] abus;
  int          error_cnt = 0, checked = 0, cycles = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  assign data_w = host_oe ? host_d : mem_d; // host wins only while it drives
  nv_shadow_host #(.SAVE_CYC(24'd40), .RESTORE_CYC(24'd30), .POWERUP_CYC(24'd20))
  u_nv_shadow_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(ready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_nv_done(nv_done), .o_addr_bus(abus), .o_data_bus(host_d),
    .o_data_bus_oe(host_oe), .i_data_bus(data_w), .o_ce_n(ce_n), .o_we_n(we_n),
    .o_oe_n(oe_n));
  nv_mem_model #(.SAVE_T(30), .RESTORE_T(20)) u_nv_mem_model (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_addr_bus(abus), .i_data_bus(data_w), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .o_data_bus(mem_d), .o_saves(saves), .o_restores(restores),
    .o_deaf_hits(deaf));
  // ==========================================================
  // compares and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang is cut after a generous multiple of the expected run
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========================================================
  // command drivers, inputs move on the falling edge
  task automatic issue(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    while (ready !== 1'b1) @(negedge i_clk_sys);
    {i_req, i_cmd, i_addr, i_wdata} = {1'b1, c, a, d};
    @(negedge i_clk_sys);
    i_req = 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    issue(2'h0, a, 8'h00);
    while (rvalid !== 1'b1) @(negedge i_clk_sys);
    d = rdata;
  endtask
  task automatic nv_op(input logic [1:0] c);
    issue(c, 13'h0000, 8'h00);
    while (nv_done !== 1'b1) @(negedge i_clk_sys);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_powerup;
    rd(13'h0005, rd_v); chk_byte(rd_v, 8'h5f);
    rd(13'h1fff, rd_v); chk_byte(rd_v, 8'ha5);
  endtask
  // writes hit the six save unlock addresses, not 0f0e; reads go backwards so no save fires
  task automatic t_rw;
    logic [12:0] tbl [6];
    tbl = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0, 13'h0f0f};
    foreach (tbl[k]) issue(2'h1, tbl[k], tbl[k][7:0] ^ 8'h33);
    for (int k = 5; k >= 0; k--) begin
      rd(tbl[k], rd_v);
      chk_byte(rd_v, tbl[k][7:0] ^ 8'h33);
    end
    chk_cnt(saves, 8'h00);
  endtask
  task automatic t_save_restore;
    issue(2'h1, 13'h0123, 8'hc3);
    nv_op(2'h2);
    chk_cnt(saves, 8'h01);
    chk_cnt(deaf, 8'h00);
    issue(2'h1, 13'h0123, 8'h3c);
    rd(13'h0123, rd_v); chk_byte(rd_v, 8'h3c);
    nv_op(2'h3);
    chk_cnt(restores, 8'h01);
    rd(13'h0123, rd_v); chk_byte(rd_v, 8'hc3);
  endtask
  task automatic t_reset_again;
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    rd(13'h0123, rd_v); chk_byte(rd_v, 8'hc3);
  endtask
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_powerup();
    t_rw();
    t_save_restore();
    t_reset_again();
    wrap_up();
  end
endmodule // nv_shadow_host_tb
`default_nettype wire
